// file: src/bdm_pkg.sv
// package: constants and carrier types for the banked data memory and config block
package bdm_pkg;

    // ==========================================
    // data space
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;
    localparam int RAM_DEPTH = 512;
    localparam logic [8:0] ADDR_IND_PORT = 9'h000;
    localparam logic [6:0] OFS_IND_PORT = 7'h00;
    localparam logic [6:0] OFS_STATUS = 7'h03;
    localparam logic [6:0] OFS_POINTER = 7'h04;
    localparam logic [6:0] OFS_PCL = 7'h02;
    localparam logic [6:0] OFS_PCLATH = 7'h0a;
    localparam logic [8:0] ADDR_RD_DELAY = 9'h113;
    localparam logic [6:0] SFR_TOP = 7'h1f;

    // ==========================================
    // status register fields
    localparam int ST_IND_BANK = 7;
    localparam int ST_BANK_HI = 6;
    localparam int ST_BANK_LO = 5;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] STATUS_SW_MASK = 8'he0;
    localparam logic [7:0] POINTER_RST = 8'h00;

    // ==========================================
    // read delay control
    localparam logic [1:0] RD_DELAY_RST = 2'h2;
    localparam logic [1:0] RD_DELAY_16NS = 2'h0;
    localparam logic [1:0] RD_DELAY_12NS = 2'h1;
    localparam logic [1:0] RD_DELAY_8NS = 2'h2;
    localparam logic [1:0] RD_DELAY_4NS = 2'h3;

    // ==========================================
    // program memory and configuration word
    localparam int CODE_WORDS = 2048;
    localparam int CFG_AREA_WORDS = 32;
    localparam logic [15:0] CFG_DEFAULT = 16'h0600;
    localparam int CFG_PROTECT = 15;
    localparam int CFG_WDT_HI = 13;
    localparam int CFG_WDT_LO = 12;
    localparam int CFG_LEVEL_HI = 11;
    localparam int CFG_LEVEL_LO = 8;
    localparam int CFG_XRST = 7;
    localparam int CFG_PSC = 5;
    localparam int CFG_POR = 4;
    localparam int CFG_TDET = 3;

    // ==========================================
    // vectors
    localparam logic [10:0] RESET_VECTOR = 11'h000;
    localparam logic [10:0] IRQ_VECTOR = 11'h004;

    typedef enum logic [1:0] {
        BDM_PM_FAST,
        BDM_PM_SLOW,
        BDM_PM_IDLE,
        BDM_PM_STOP
    } bdm_pmode_t;

    typedef enum logic [1:0] {
        BDM_ACC_DIRECT,
        BDM_ACC_EXT,
        BDM_ACC_NONE
    } bdm_acc_t;

    // cpu data access request
    typedef struct packed {
        logic rd;
        logic wr;
        logic ext;
        logic [8:0] addr;
        logic [7:0] wdata;
        logic [7:0] flags;
        logic flags_we;
    } bdm_cpu_req_t;

    // programmer request
    typedef struct packed {
        logic rd;
        logic wr;
        logic erase;
        logic cfg_sel;
        logic [10:0] addr;
        logic [15:0] wdata;
    } bdm_prog_req_t;

    // decoded configuration outputs
    typedef struct packed {
        logic wdt_en;
        logic [3:0] low_voltage_reset_level;
        logic low_voltage_reset_en;
        logic ext_reset_pin_enable;
        logic fast_osc_prescale;
        logic power_on_reset_duty;
        logic transient_detect_off;
    } bdm_cfg_out_t;

endpackage : bdm_pkg

// file: src/bdm_ram.sv
// file holds the general data memory with a registered read port
module bdm_ram (
    input wire logic clk_sys,
    input wire logic we,
    input wire logic [8:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [8:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem [bdm_pkg::RAM_DEPTH];

    // no reset on storage: contents are undefined until written
    always_ff @(posedge clk_sys)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : bdm_ram

// file: src/bdm_core.sv
// file holds the banked data addressing, configuration word and vector logic
module bdm_core (
    input wire logic clk_sys,
    input wire logic srst,
    input wire bdm_pkg::bdm_cpu_req_t cpu_req,
    output logic [7:0] cpu_rdata,
    output logic cpu_rvalid,
    input wire logic irq_take,
    input wire logic [10:0] pc_now,
    output logic push_req,
    output logic [10:0] push_data,
    output logic fetch_load,
    output logic [10:0] fetch_addr,
    input wire bdm_pkg::bdm_prog_req_t prog_req,
    output logic [15:0] prog_rdata,
    output logic prog_rvalid,
    output logic prog_refused,
    output logic [10:0] code_addr,
    output logic [15:0] code_wdata,
    output logic code_we,
    output logic code_erase,
    input wire logic [15:0] code_rdata,
    input wire bdm_pkg::bdm_pmode_t power_mode,
    output bdm_pkg::bdm_cfg_out_t cfg_out,
    output logic [1:0] rom_read_delay,
    output logic [7:0] core_status
);
    // ==========================================
    // state
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] pointer;
        logic [1:0] rd_delay;
        logic [15:0] cfg;
        logic code_blank;
        logic [7:0] rdata;
        logic rvalid;
        logic rd_zero;
        logic rd_ram;
        logic [15:0] prdata;
        logic prvalid;
        logic prd_code;
        logic prefused;
        logic [10:0] caddr;
        logic [15:0] cwdata;
        logic cwe;
        logic cerase;
        logic push;
        logic [10:0] pushd;
        logic fload;
        logic [10:0] faddr;
        bdm_pkg::bdm_cfg_out_t cfgo;
    } bdm_state_t;

    bdm_state_t st_q;
    bdm_state_t st_d;
    logic [8:0] eff_addr;
    logic eff_zero;
    logic ram_we;
    logic [7:0] ram_rdata;

    // mirrored sfr offsets decode the same in every bank
    function automatic logic is_shared(input logic [8:0] a, input logic [6:0] ofs);
        is_shared = (a[6:0] == ofs);
    endfunction : is_shared

    // ==========================================
    // address formation
    always_comb
    begin
        eff_zero = 1'b0;
        if (cpu_req.ext)
        begin
            eff_addr = cpu_req.addr;
        end
        else
        begin
            eff_addr = {st_q.status[bdm_pkg::ST_BANK_HI], st_q.status[bdm_pkg::ST_BANK_LO],
                        cpu_req.addr[6:0]};
        end
        if (is_shared(eff_addr, bdm_pkg::OFS_IND_PORT))
        begin
            eff_addr = {st_q.status[bdm_pkg::ST_IND_BANK], st_q.pointer};
            eff_zero = (st_q.pointer == bdm_pkg::POINTER_RST)
                || is_shared(eff_addr, bdm_pkg::OFS_IND_PORT);
        end
    end

    // general storage only above the special registers; mirrors never reach it
    assign ram_we = cpu_req.wr && !eff_zero && (eff_addr[6:0] > bdm_pkg::SFR_TOP);

    bdm_ram u_ram (
        .clk_sys(clk_sys),
        .we(ram_we),
        .waddr(eff_addr),
        .wdata(cpu_req.wdata),
        .raddr(eff_addr),
        .rdata(ram_rdata)
    );

    // ==========================================
    // next state
    always_comb
    begin
        st_d = st_q;
        st_d.rvalid = cpu_req.rd;
        st_d.rd_zero = 1'b0;
        st_d.rd_ram = 1'b0;
        st_d.prvalid = prog_req.rd;
        st_d.prd_code = 1'b0;
        st_d.prefused = 1'b0;
        st_d.cwe = 1'b0;
        st_d.cerase = 1'b0;
        st_d.push = 1'b0;
        st_d.fload = 1'b0;

        // cpu side flag update comes first so an explicit write wins on bank bits
        if (cpu_req.flags_we)
        begin
            st_d.status = (st_q.status & bdm_pkg::STATUS_SW_MASK)
                | (cpu_req.flags & ~bdm_pkg::STATUS_SW_MASK);
        end
        if (cpu_req.rd)
        begin
            st_d.rd_zero = eff_zero;
            if (is_shared(eff_addr, bdm_pkg::OFS_STATUS))
            begin
                st_d.rdata = st_q.status;
            end
            else if (is_shared(eff_addr, bdm_pkg::OFS_POINTER))
            begin
                st_d.rdata = st_q.pointer;
            end
            else if (eff_addr == bdm_pkg::ADDR_RD_DELAY)
            begin
                st_d.rdata = {6'h00, st_q.rd_delay};
            end
            else if (eff_addr[6:0] > bdm_pkg::SFR_TOP)
            begin
                st_d.rd_ram = 1'b1;
                st_d.rdata = 8'h00;
            end
            else
            begin
                st_d.rdata = 8'h00;
            end
        end
        if (cpu_req.wr && !eff_zero)
        begin
            if (is_shared(eff_addr, bdm_pkg::OFS_STATUS))
            begin
                // flag bits stay with the alu when it also updates them
                st_d.status = cpu_req.flags_we
                    ? {cpu_req.wdata[7:5], st_d.status[4:0]}
                    : {cpu_req.wdata[7:5], st_q.status[4:3], cpu_req.wdata[2:0]};
            end
            else if (is_shared(eff_addr, bdm_pkg::OFS_POINTER))
            begin
                st_d.pointer = cpu_req.wdata;
            end
            else if (eff_addr == bdm_pkg::ADDR_RD_DELAY)
            begin
                st_d.rd_delay = cpu_req.wdata[1:0];
            end
        end

        if (irq_take)
        begin
            st_d.push = 1'b1;
            st_d.pushd = pc_now;
            st_d.fload = 1'b1;
            st_d.faddr = bdm_pkg::IRQ_VECTOR;
        end

        if (prog_req.wr && prog_req.cfg_sel)
        begin
            if (st_q.cfg[bdm_pkg::CFG_PROTECT] && !prog_req.wdata[bdm_pkg::CFG_PROTECT]
                && !st_q.code_blank)
            begin
                st_d.prefused = 1'b1;
            end
            else
            begin
                st_d.cfg = prog_req.wdata;
            end
        end
        else if (prog_req.wr)
        begin
            if (st_q.cfg[bdm_pkg::CFG_PROTECT])
            begin
                st_d.prefused = 1'b1;
            end
            else
            begin
                st_d.cwe = 1'b1;
                st_d.caddr = prog_req.addr;
                st_d.cwdata = prog_req.wdata;
                st_d.code_blank = 1'b0;
            end
        end
        else if (prog_req.erase)
        begin
            st_d.cerase = 1'b1;
            st_d.code_blank = 1'b1;
        end
        if (prog_req.rd)
        begin
            if (prog_req.cfg_sel)
            begin
                st_d.prdata = st_q.cfg;
            end
            else if (st_q.cfg[bdm_pkg::CFG_PROTECT])
            begin
                st_d.prdata = 16'h0000;
                st_d.prefused = 1'b1;
            end
            else
            begin
                st_d.prd_code = 1'b1;
                st_d.caddr = prog_req.addr;
                st_d.prdata = 16'h0000;
            end
        end

        unique case (st_q.cfg[bdm_pkg::CFG_WDT_HI:bdm_pkg::CFG_WDT_LO])
            2'h3: st_d.cfgo.wdt_en = 1'b1;
            2'h2: st_d.cfgo.wdt_en = (power_mode == bdm_pkg::BDM_PM_FAST)
                || (power_mode == bdm_pkg::BDM_PM_SLOW);
            default: st_d.cfgo.wdt_en = 1'b0;
        endcase
        st_d.cfgo.low_voltage_reset_level = st_q.cfg[bdm_pkg::CFG_LEVEL_HI:bdm_pkg::CFG_LEVEL_LO];
        st_d.cfgo.low_voltage_reset_en = (st_d.cfgo.low_voltage_reset_level != 4'h0);
        st_d.cfgo.ext_reset_pin_enable = st_q.cfg[bdm_pkg::CFG_XRST];
        st_d.cfgo.fast_osc_prescale = st_q.cfg[bdm_pkg::CFG_PSC];
        st_d.cfgo.power_on_reset_duty = st_q.cfg[bdm_pkg::CFG_POR];
        st_d.cfgo.transient_detect_off = st_q.cfg[bdm_pkg::CFG_TDET];
    end

    // ==========================================
    // registers
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            st_q <= '0;
            st_q.status <= bdm_pkg::STATUS_RST;
            st_q.pointer <= bdm_pkg::POINTER_RST;
            st_q.rd_delay <= bdm_pkg::RD_DELAY_RST;
            st_q.fload <= 1'b1;
            st_q.faddr <= bdm_pkg::RESET_VECTOR;
            // non-volatile word is kept across reset
            st_q.cfg <= st_q.cfg;
            st_q.code_blank <= st_q.code_blank;
            st_q.cfgo <= st_q.cfgo;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ==========================================
    // outputs; ram and code reads merge here, one cycle after the request
    always_comb
    begin
        cpu_rdata = st_q.rd_zero ? 8'h00 : (st_q.rd_ram ? ram_rdata : st_q.rdata);
        prog_rdata = st_q.prd_code ? code_rdata : st_q.prdata;
    end
    assign cpu_rvalid = st_q.rvalid;
    assign prog_rvalid = st_q.prvalid;
    assign prog_refused = st_q.prefused;
    assign code_addr = st_q.caddr;
    assign code_wdata = st_q.cwdata;
    assign code_we = st_q.cwe;
    assign code_erase = st_q.cerase;
    assign push_req = st_q.push;
    assign push_data = st_q.pushd;
    assign fetch_load = st_q.fload;
    assign fetch_addr = st_q.faddr;
    assign cfg_out = st_q.cfgo;
    assign rom_read_delay = st_q.rd_delay;
    assign core_status = st_q.status;
endmodule : bdm_core

// file: bench/bdm_core_properties.sv
// checker: port-level properties of the banked data core
module bdm_core_properties (
    input wire logic clk_sys,
    input wire logic srst,
    input wire bdm_pkg::bdm_cpu_req_t cpu_req,
    input wire logic cpu_rvalid,
    input wire logic irq_take,
    input wire logic [10:0] pc_now,
    input wire logic push_req,
    input wire logic [10:0] push_data,
    input wire logic fetch_load,
    input wire logic [10:0] fetch_addr,
    input wire bdm_pkg::bdm_prog_req_t prog_req,
    input wire logic [15:0] prog_rdata,
    input wire logic prog_rvalid,
    input wire logic prog_refused,
    input wire logic code_we,
    input wire bdm_pkg::bdm_cfg_out_t cfg_out,
    input wire logic [1:0] rom_read_delay,
    input wire logic [7:0] core_status
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // properties
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    chk_read_answer: assert property (cpu_rvalid == $past(cpu_req.rd))
        else $error("read answer not one cycle after request");
    chk_irq_vector: assert property (irq_take |=> push_req && fetch_load
        && push_data == $past(pc_now) && fetch_addr == bdm_pkg::IRQ_VECTOR)
        else $error("interrupt push or vector wrong");
    chk_reset_vector: assert property ($fell(srst) |-> ##[0:1]
        (fetch_load && fetch_addr == bdm_pkg::RESET_VECTOR))
        else $error("no fetch from reset vector");
    chk_reset_values: assert property ($fell(srst) |-> core_status == 8'h00
        && rom_read_delay == bdm_pkg::RD_DELAY_RST)
        else $error("reset values wrong");
    chk_delay_write: assert property (cpu_req.wr && cpu_req.ext
        && cpu_req.addr == bdm_pkg::ADDR_RD_DELAY
        |=> rom_read_delay == $past(cpu_req.wdata[1:0]))
        else $error("read delay not written");
    chk_status_write: assert property (cpu_req.wr && !cpu_req.flags_we
        && cpu_req.addr[6:0] == bdm_pkg::OFS_STATUS
        |=> core_status[7:5] == $past(cpu_req.wdata[7:5]) && $stable(core_status[4:3]))
        else $error("status write wrong");
    chk_code_guard: assert property (prog_req.wr && !prog_req.cfg_sel
        |=> code_we != prog_refused)
        else $error("code write neither done nor refused");
    chk_read_hidden: assert property (prog_req.rd && !prog_req.cfg_sel
        |=> prog_rvalid && (!prog_refused || prog_rdata == 16'h0000))
        else $error("protected code leaked");
    chk_cfg_level: assert property (prog_req.wr && prog_req.cfg_sel ##1 !prog_refused
        |=> cfg_out.low_voltage_reset_level == $past(prog_req.wdata[11:8], 2)
        && cfg_out.low_voltage_reset_en == (cfg_out.low_voltage_reset_level != 4'h0))
        else $error("reset level decode wrong");
endmodule : bdm_core_properties

bind bdm_core bdm_core_properties bdm_core_properties_i (.*);

// file: bench/bdm_code_model.sv
// partner model: external code array behind the programmer port
module bdm_code_model (
    input wire logic clk_sys,
    input wire logic [10:0] code_addr,
    input wire logic [15:0] code_wdata,
    input wire logic code_we,
    input wire logic code_erase,
    output logic [15:0] code_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // code array
    // 2K user words
    logic [15:0] mem_q [bdm_pkg::CODE_WORDS];
    always_ff @(posedge clk_sys)
    begin
        if (code_erase)
        begin
            for (int i = 0; i < bdm_pkg::CODE_WORDS; i++)
            begin
                mem_q[i] <= 16'hffff;
            end
        end
        else if (code_we)
        begin
            mem_q[code_addr] <= code_wdata;
        end
    end
    // unwritten words stay unknown, so a stray read cannot pass by luck
    assign code_rdata = mem_q[code_addr];
endmodule : bdm_code_model

// file: bench/test_bdm_core.sv
// testbench: directed scenarios for the banked data core
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("Error %s exp %h got %h", nm, (e), (g)); end end

module test_bdm_core;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // signals and instances
    logic clk_sys = 1'b0;
    logic srst;
    logic irq_take = 1'b0;
    logic [10:0] pc_now = 11'h000;
    bdm_pkg::bdm_cpu_req_t cpu_req = '0;
    bdm_pkg::bdm_prog_req_t prog_req = '0;
    bdm_pkg::bdm_pmode_t power_mode = bdm_pkg::BDM_PM_FAST;
    bdm_pkg::bdm_cfg_out_t cfg_out;
    logic cpu_rvalid, push_req, fetch_load, prog_rvalid, prog_refused, code_we, code_erase;
    logic [10:0] push_data, fetch_addr, code_addr;
    logic [7:0] cpu_rdata, core_status;
    logic [15:0] prog_rdata, code_wdata, code_rdata;
    logic [1:0] rom_read_delay;
    logic [8:0] rd_seen;
    logic [17:0] pg_seen;
    logic [23:0] irq_seen;
    int bad_count = 0;
    int n_tests = 0;
    int cyc = 0;

    bdm_core bdm_core_i (.*);
    bdm_code_model bdm_code_model_i (.*);

    initial
    begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    // the whole run needs well under a thousand cycles
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            bad_count++;
            give_verdict;
        end
    end

    task automatic give_verdict;
        if (bad_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    task automatic tick;
        @(posedge clk_sys);
        #2;
    endtask : tick

    // one request cycle, then an idle cycle so no strobe is set twice at once
    task automatic cpu(input logic w, input logic x, input logic [8:0] a, input logic [7:0] d);
        cpu_req.rd = !w;
        cpu_req.wr = w;
        cpu_req.ext = x;
        cpu_req.addr = a;
        cpu_req.wdata = d;
        tick;
        rd_seen = {cpu_rvalid, cpu_rdata};
        cpu_req.rd = 1'b0;
        cpu_req.wr = 1'b0;
        cpu_req.flags_we = 1'b0;
        tick;
    endtask : cpu

    task automatic rdc(input logic x, input logic [8:0] a, input logic [7:0] e);
        cpu(1'b0, x, a, 8'h00);
        `CHK("cpu_rdata", {1'b1, e}, rd_seen);
    endtask : rdc

    // op 0 read, 1 write, 2 erase; cfg_out settles by the end
    task automatic prog(input int op, input logic cs, input logic [10:0] a, input logic [15:0] d);
        prog_req.rd = (op == 0);
        prog_req.wr = (op == 1);
        prog_req.erase = (op == 2);
        prog_req.cfg_sel = cs;
        prog_req.addr = a;
        prog_req.wdata = d;
        tick;
        pg_seen = {prog_refused, prog_rvalid, prog_rdata};
        prog_req.rd = 1'b0;
        prog_req.wr = 1'b0;
        prog_req.erase = 1'b0;
        tick;
    endtask : prog

    task automatic t_reset;
        srst = 1'b1;
        repeat (3) tick;
        srst = 1'b0;
        tick;
        `CHK("rom_read_delay", bdm_pkg::RD_DELAY_RST, rom_read_delay);
        `CHK("core_status", bdm_pkg::STATUS_RST, core_status);
        `CHK("fetch_addr", bdm_pkg::RESET_VECTOR, fetch_addr);
    endtask : t_reset

    task automatic t_config;
        prog(1, 1'b1, 11'h000, bdm_pkg::CFG_DEFAULT);
        `CHK("cfg_out", 10'h0d0, cfg_out);
        prog(0, 1'b1, 11'h000, 16'h0000);
        `CHK("cfg read", {1'b1, bdm_pkg::CFG_DEFAULT}, pg_seen[16:0]);
        prog(1, 1'b1, 11'h000, 16'h39b8);
        `CHK("cfg_out", 10'h33f, cfg_out);
        prog(1, 1'b1, 11'h000, 16'h0f20);
        `CHK("cfg_out", 10'h1f4, cfg_out);
        for (int m = 0; m < 4; m++)
            for (int w = 0; w < 4; w++)
            begin
                power_mode = bdm_pkg::bdm_pmode_t'(m);
                prog(1, 1'b1, 11'h000, {2'b00, w[1:0], 12'h000});
                `CHK("wdt_en", w[1] && (w[0] || m < 2), cfg_out.wdt_en);
            end
    endtask : t_config

    task automatic t_protect;
        prog(1, 1'b1, 11'h000, bdm_pkg::CFG_DEFAULT);
        prog(1, 1'b0, 11'h005, 16'h1234);
        prog(0, 1'b0, 11'h005, 16'h0000);
        `CHK("code read", 18'h11234, pg_seen);
        prog(1, 1'b1, 11'h000, 16'h8600);
        prog(0, 1'b0, 11'h005, 16'h0000);
        `CHK("hidden read", 18'h30000, pg_seen);
        prog(1, 1'b0, 11'h005, 16'habcd);
        `CHK("locked write", 1'b1, pg_seen[17]);
        prog(0, 1'b1, 11'h000, 16'h0000);
        `CHK("cfg read", 18'h18600, pg_seen);
        prog(1, 1'b1, 11'h000, bdm_pkg::CFG_DEFAULT);
        `CHK("unlock unerased", 1'b1, pg_seen[17]);
        prog(2, 1'b0, 11'h000, 16'h0000);
        prog(1, 1'b1, 11'h000, bdm_pkg::CFG_DEFAULT);
        `CHK("unlock erased", 1'b0, pg_seen[17]);
        prog(0, 1'b0, 11'h005, 16'h0000);
        `CHK("erased code", 18'h1ffff, pg_seen);
    endtask : t_protect

    task automatic t_delay;
        power_mode = bdm_pkg::BDM_PM_SLOW;
        for (int i = 0; i < 4; i++)
        begin
            cpu(1'b1, 1'b1, bdm_pkg::ADDR_RD_DELAY, 8'(i));
            `CHK("rom_read_delay", 2'(i), rom_read_delay);
            rdc(1'b1, bdm_pkg::ADDR_RD_DELAY, 8'(i));
        end
        cpu(1'b1, 1'b1, 9'h003, 8'h40);
        cpu(1'b1, 1'b0, 9'h013, 8'h00);
        `CHK("direct delay", bdm_pkg::RD_DELAY_16NS, rom_read_delay);
        power_mode = bdm_pkg::BDM_PM_FAST;
    endtask : t_delay

    task automatic t_banks;
        for (int b = 0; b < 4; b++)
        begin
            cpu(1'b1, 1'b0, 9'h003, {1'b0, 2'(b), 5'h00});
            `CHK("bank", 3'(b), core_status[7:5]);
            cpu(1'b1, 1'b0, 9'h020, 8'h40 + 8'(b));
        end
        for (int b = 0; b < 4; b++)
        begin
            rdc(1'b1, {2'(b), 7'h20}, 8'h40 + 8'(b));
        end
        cpu(1'b1, 1'b1, 9'h001, 8'h77);
        rdc(1'b1, 9'h001, 8'h00);
        cpu(1'b1, 1'b1, 9'h183, 8'hff);
        rdc(1'b1, 9'h003, 8'he7);
    endtask : t_banks

    task automatic t_indirect;
        cpu(1'b1, 1'b1, 9'h004, 8'h20);
        cpu(1'b1, 1'b1, 9'h003, 8'h80);
        rdc(1'b1, 9'h000, 8'h42);
        cpu(1'b1, 1'b1, 9'h003, 8'h00);
        rdc(1'b0, 9'h080, 8'h40);
        cpu(1'b1, 1'b1, 9'h004, 8'ha0);
        cpu(1'b1, 1'b1, 9'h000, 8'h5a);
        rdc(1'b1, 9'h0a0, 8'h5a);
        cpu(1'b1, 1'b1, 9'h004, 8'h00);
        rdc(1'b1, 9'h000, 8'h00);
        cpu_req.flags = 8'h15;
        cpu_req.flags_we = 1'b1;
        cpu(1'b1, 1'b1, 9'h000, 8'h99);
        `CHK("flags", 8'h15, core_status);
    endtask : t_indirect

    task automatic t_irq;
        pc_now = 11'h155;
        irq_take = 1'b1;
        tick;
        irq_seen = {push_req, fetch_load, push_data, fetch_addr};
        `CHK("irq", {2'b11, 11'h155, bdm_pkg::IRQ_VECTOR}, irq_seen);
        irq_take = 1'b0;
        tick;
    endtask : t_irq

    // mid-run reset keeps the non-volatile word
    task automatic t_keep;
        t_reset;
        `CHK("cfg kept", 10'h0d0, cfg_out);
    endtask : t_keep

    initial
    begin
        t_reset;
        t_config;
        t_protect;
        t_delay;
        t_banks;
        t_indirect;
        t_irq;
        t_keep;
        give_verdict;
    end
endmodule : test_bdm_core
